// ---- synth_cfg_pkg.sv ----
// Constants shared by both ends of the synthesizer configuration link.
// Assumes a single 20 MHz system clock on each end.
package synth_cfg_pkg;

  // ****************************************
  // Word and register selection
  // ****************************************
  localparam int         WORD_W       = 32;
  localparam int         NUM_REGS     = 6;
  localparam logic [2:0] SEL_INT_FRACTIONAL_NUMERATOR = 3'h0;
  localparam logic [2:0] SEL_MOD      = 3'h1;
  localparam logic [2:0] SEL_REF      = 3'h2;
  localparam logic [2:0] SEL_CSR      = 3'h3;
  localparam logic [2:0] SEL_OUT_BAND = 3'h4;
  localparam logic [2:0] SEL_LOCK_PIN = 3'h5;
  localparam logic [31:0] WORD_RESET  = 32'h0000_0000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int INT_LSB     = 15;
  localparam int FRACTIONAL_NUMERATOR_LSB    = 3;
  localparam int MOD_LSB     = 3;
  localparam int DBL_BIT     = 25;
  localparam int HALF_BIT    = 24;
  localparam int RCNT_LSB    = 14;
  localparam int CSR_BIT     = 18;
  localparam int DIVSEL_LSB  = 20;
  localparam int BAND_LSB    = 12;
  localparam int VCO_PD_BIT  = 11;
  localparam int MUTE_BIT    = 10;
  localparam int AUX_SEL_BIT = 9;
  localparam int AUX_EN_BIT  = 8;
  localparam int AUX_PWR_LSB = 6;
  localparam int RF_EN_BIT   = 5;
  localparam int RF_PWR_LSB  = 3;
  localparam int LD_MODE_LSB = 22;

  // ****************************************
  // Lock pin modes
  // ****************************************
  localparam logic [1:0] LD_MODE_LOW  = 2'h0;
  localparam logic [1:0] LD_MODE_LOCK = 2'h1;
  localparam logic [1:0] LD_MODE_HIGH = 2'h3;

  // ****************************************
  // Counts and limits
  // ****************************************
  localparam logic [5:0]  LOCK_CYCLES      = 6'h28;
  localparam logic [2:0]  CP_CELLS_MAX     = 3'h7;
  localparam int          PHASE_ERR_NS     = 10;
  localparam logic [31:0] BAND_CLK_MAX_KHZ = 32'h0000_007D;
  localparam logic [31:0] PFD_MAX_KHZ      = 32'h0000_7D00;
  localparam int          SYS_CLK_KHZ      = 20000;
  localparam int          SER_PHASE_NS     = 200;
  localparam int          SER_PHASE_CYCLES = (SER_PHASE_NS * SYS_CLK_KHZ + 999999) / 1000000;

endpackage : synth_cfg_pkg

// ---- synth_serial_if.sv ----
// Three-wire serial link between host and synthesizer configuration logic.
// Assumes the host drives all three wires; the device only listens.
`timescale 1ns/1ps
interface synth_serial_if;
  logic ser_clk;
  logic ser_data;
  logic ser_le;

  modport host   (output ser_clk, output ser_data, output ser_le);
  modport device (input ser_clk, input ser_data, input ser_le);
endinterface : synth_serial_if

// ---- synth_cfg_host.sv ----
// Host end: sends control words over the serial link in the power-up order.
// Assumes word_in is held stable while word_valid_in is high.
`timescale 1ns/1ps
module synth_cfg_host
  import synth_cfg_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  synth_serial_if.host     link,
  input  wire logic [31:0] word_in,
  input  wire logic        word_valid_in,
  output logic             word_ready_out,
  input  wire logic [15:0] ref_khz_in,
  input  wire logic        ref_duty_ok_in,
  output logic             init_done_out,
  output logic             order_err_out,
  output logic             limit_warn_out
);

  typedef enum logic [2:0] {S_IDLE, S_LOW, S_HIGH, S_LATCH, S_GAP} host_state_t;

  host_state_t state_reg;
  logic [2:0]  tick_cnt_reg;
  logic [31:0] shift_reg;
  logic [4:0]  bit_cnt_reg;
  logic [2:0]  expect_reg;
  logic        init_done_reg;
  logic        csr_req_reg;
  logic        dbl_reg;
  logic [9:0]  rdiv_reg;
  logic        order_err_reg;
  logic        warn_reg;

  // ****************************************
  // Word acceptance and checks
  // ****************************************
  wire        tick       = (tick_cnt_reg == 3'(SER_PHASE_CYCLES - 1));
  wire        take       = word_valid_in && (state_reg == S_IDLE);
  wire [2:0]  sel        = word_in[2:0];
  wire        in_order   = init_done_reg || (sel == expect_reg);
  wire        force_half = (sel == SEL_REF) && csr_req_reg && !ref_duty_ok_in;
  wire [31:0] word_send  = force_half ? (word_in | (32'h0000_0001 << HALF_BIT)) : word_in;
  wire        new_dbl    = word_send[DBL_BIT];
  wire        new_half   = word_send[HALF_BIT];
  wire [9:0]  new_rdiv   = word_send[RCNT_LSB +: 10];
  wire [31:0] ref_scaled = {15'h0000, ref_khz_in, 1'b0} >> (new_dbl ? 0 : 1);
  wire [31:0] r_eff      = {21'h00_0000, (new_rdiv == 10'h000) ? 10'h001 : new_rdiv, 1'b0} >> (new_half ? 0 : 1);
  wire [31:0] ref_old    = {15'h0000, ref_khz_in, 1'b0} >> (dbl_reg ? 0 : 1);
  wire [31:0] r_old      = {22'h00_0000, (rdiv_reg == 10'h000) ? 10'h001 : rdiv_reg};
  wire [7:0]  bdiv       = (word_in[BAND_LSB +: 8] == 8'h00) ? 8'h01 : word_in[BAND_LSB +: 8];
  wire        pfd_high   = (sel == SEL_REF) && (ref_scaled > PFD_MAX_KHZ * r_eff);
  wire        band_high  = (sel == SEL_OUT_BAND) && (ref_old > BAND_CLK_MAX_KHZ * r_old * {24'h00_0000, bdiv});

  assign word_ready_out = (state_reg == S_IDLE);
  assign init_done_out  = init_done_reg;
  assign order_err_out  = order_err_reg;
  assign limit_warn_out = warn_reg;
  assign link.ser_clk   = (state_reg == S_HIGH);
  assign link.ser_data  = shift_reg[31];
  assign link.ser_le    = (state_reg == S_LATCH);

  // ****************************************
  // Phase divider and sequencer
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_reg <= 3'h0;
    end else if (state_reg == S_IDLE || tick) begin
      tick_cnt_reg <= 3'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg     <= S_IDLE;
      shift_reg     <= WORD_RESET;
      bit_cnt_reg   <= 5'h00;
      expect_reg    <= SEL_LOCK_PIN;
      init_done_reg <= 1'b0;
      csr_req_reg   <= 1'b0;
      dbl_reg       <= 1'b0;
      rdiv_reg      <= 10'h001;
      order_err_reg <= 1'b0;
      warn_reg      <= 1'b0;
    end else begin
      order_err_reg <= take && !in_order;
      warn_reg      <= take && in_order && (pfd_high || band_high);
      case (state_reg)
        S_IDLE: begin
          if (take && in_order) begin
            state_reg   <= S_LOW;
            shift_reg   <= word_send;
            bit_cnt_reg <= 5'h1F;
            if (!init_done_reg) begin
              expect_reg    <= expect_reg - 3'h1;
              init_done_reg <= (sel == SEL_INT_FRACTIONAL_NUMERATOR);
            end
            if (sel == SEL_CSR) begin
              csr_req_reg <= word_in[CSR_BIT];
            end
            if (sel == SEL_REF) begin
              dbl_reg  <= new_dbl;
              rdiv_reg <= new_rdiv;
            end
          end
        end
        S_LOW: begin
          if (tick) begin
            state_reg <= S_HIGH;
          end
        end
        S_HIGH: begin
          if (tick) begin
            shift_reg   <= {shift_reg[30:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg - 5'h01;
            state_reg   <= (bit_cnt_reg == 5'h00) ? S_LATCH : S_LOW;
          end
        end
        S_LATCH: begin
          if (tick) begin
            state_reg <= S_GAP;
          end
        end
        S_GAP: begin
          if (tick) begin
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule : synth_cfg_host

// ---- synth_cfg_device.sv ----
// Device end: latches control words and drives output, band and lock logic.
// Assumes serial link, reference and loop status inputs are asynchronous
// and each level lasts at least three system clocks.
`timescale 1ns/1ps
// How it works
// - Band select clock divides reference counter output.
// - Host flags band select clock above 125 kHz on limit_warn_out.
// - Word four bit 11 powers VCO down.
// - Mute holds primary RF output off until lock.
// - Bit 9 picks divided or direct VCO.
// - Bit 8 enables auxiliary RF output.
// - Bits 7-6 set auxiliary output power.
// - Bit 5 enables primary RF output.
// - Bits 4-3 set primary output power.
// - Select bits 101 write word five.
// - Word five bits 23-22 set lock pin.
// - Host writes words five down to zero.
// - Output ratio is N plus fraction over divider.
// - Comparison ratio (1+D) over R times (1+T).
// - Host flags comparison rate above 32 MHz on limit_warn_out.
// - Fractional modulus is twelve bits wide.
// - Each imminent slip adds a cell, seven maximum.
// - Past target, cells drop one by one.
// - Word three bit 18 enables slip reduction.
// - Host forces halving when duty cycle is poor and slip reduction is on.
// - Halving divides reference counter output by two.
// - Select bits 100 write word four.
// - Lock after 40 good comparison cycles.
module synth_cfg_device
  import synth_cfg_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  synth_serial_if.device   link,
  input  wire logic        ref_in,
  input  wire logic        phase_ok_in,
  input  wire logic        slip_imminent_in,
  input  wire logic        past_target_in,
  output logic             vco_en_out,
  output logic             rf_en_out,
  output logic [1:0]       rf_pwr_out,
  output logic             aux_en_out,
  output logic             aux_sel_out,
  output logic [1:0]       aux_pwr_out,
  output logic [2:0]       div_sel_out,
  output logic             band_tick_out,
  output logic             cmp_pulse_out,
  output logic             digital_lock_out,
  output logic             ld_pin_out,
  output logic             csr_en_out,
  output logic [2:0]       cp_cells_out,
  output logic [11:0]      fractional_modulus_out,
  output logic [27:0]      vco_ratio_num_out,
  output logic [15:0]      out_ratio_den_out,
  output logic [1:0]       pfd_ratio_num_out,
  output logic [10:0]      pfd_ratio_den_out
);

  logic [6:0]  sync1_reg;
  logic [6:0]  sync2_reg;
  logic [6:0]  prev_reg;
  logic [31:0] shift_reg;
  logic [31:0] word_reg [NUM_REGS];
  logic [9:0]  r_cnt_reg;
  logic        r_pulse_reg;
  logic        half_reg;
  logic        cmp_pulse_reg;
  logic [7:0]  band_cnt_reg;
  logic        band_tick_reg;
  logic [5:0]  lock_cnt_reg;
  logic        lock_reg;
  logic [2:0]  cells_reg;
  logic        falling_reg;
  logic [27:0] vco_num_reg;
  logic [15:0] out_den_reg;
  logic [10:0] pfd_den_reg;

  // ****************************************
  // Input synchronisers and edges
  // ****************************************
  wire [6:0] raw_in = {past_target_in, slip_imminent_in, phase_ok_in, ref_in, link.ser_le, link.ser_data, link.ser_clk};
  wire       sclk_rise = sync2_reg[0] && !prev_reg[0];
  wire       sdata     = sync2_reg[1];
  wire       le_rise   = sync2_reg[2] && !prev_reg[2];
  wire       ref_rise  = sync2_reg[3] && !prev_reg[3];
  wire       ref_fall  = !sync2_reg[3] && prev_reg[3];
  wire       phase_ok  = sync2_reg[4];
  wire       slip      = sync2_reg[5];
  wire       past      = sync2_reg[6];

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
      prev_reg  <= 7'h00;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // ****************************************
  // Serial shift and word latch
  // ****************************************
  wire [2:0] sel = shift_reg[2:0];

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_reg <= WORD_RESET;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[30:0], sdata};
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        word_reg[i] <= WORD_RESET;
      end
    end else if (le_rise && (sel <= SEL_LOCK_PIN)) begin
      word_reg[sel] <= shift_reg;
    end
  end

  // ****************************************
  // Field decode
  // ****************************************
  wire [31:0] w_out   = word_reg[SEL_OUT_BAND];
  wire [15:0] n_int   = word_reg[SEL_INT_FRACTIONAL_NUMERATOR][INT_LSB +: 16];
  wire [11:0] n_fractional_numerator  = word_reg[SEL_INT_FRACTIONAL_NUMERATOR][FRACTIONAL_NUMERATOR_LSB +: 12];
  wire [11:0] n_mod   = word_reg[SEL_MOD][MOD_LSB +: 12];
  wire        dbl     = word_reg[SEL_REF][DBL_BIT];
  wire        halving = word_reg[SEL_REF][HALF_BIT];
  wire [9:0]  r_div   = word_reg[SEL_REF][RCNT_LSB +: 10];
  wire [9:0]  r_last  = (r_div == 10'h000) ? 10'h000 : r_div - 10'h001;
  wire        csr_en  = word_reg[SEL_CSR][CSR_BIT];
  wire [7:0]  b_div   = w_out[BAND_LSB +: 8];
  wire [7:0]  b_last  = (b_div == 8'h00) ? 8'h00 : b_div - 8'h01;
  wire [1:0]  ld_mode = word_reg[SEL_LOCK_PIN][LD_MODE_LSB +: 2];
  wire        vco_on  = !w_out[VCO_PD_BIT];
  wire        muted   = w_out[MUTE_BIT] && !lock_reg;

  assign vco_en_out             = vco_on;
  assign rf_en_out              = w_out[RF_EN_BIT] && vco_on && !muted;
  assign rf_pwr_out             = w_out[RF_PWR_LSB +: 2];
  assign aux_en_out             = w_out[AUX_EN_BIT] && vco_on;
  assign aux_sel_out            = w_out[AUX_SEL_BIT];
  assign aux_pwr_out            = w_out[AUX_PWR_LSB +: 2];
  assign div_sel_out            = w_out[DIVSEL_LSB +: 3];
  assign band_tick_out          = band_tick_reg;
  assign cmp_pulse_out          = cmp_pulse_reg;
  assign digital_lock_out       = lock_reg;
  assign csr_en_out             = csr_en;
  assign cp_cells_out           = cells_reg;
  assign fractional_modulus_out = n_mod;
  assign vco_ratio_num_out      = vco_num_reg;
  assign out_ratio_den_out      = out_den_reg;
  assign pfd_ratio_num_out      = {1'b0, 1'b1} + {1'b0, dbl};
  assign pfd_ratio_den_out      = pfd_den_reg;
  assign ld_pin_out             = (ld_mode == LD_MODE_HIGH) || ((ld_mode == LD_MODE_LOCK) && lock_reg);

  // ****************************************
  // Frequency ratios
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vco_num_reg <= 28'h000_0000;
      out_den_reg <= 16'h0000;
      pfd_den_reg <= 11'h000;
    end else begin
      vco_num_reg <= n_int * n_mod + {16'h0000, n_fractional_numerator};
      out_den_reg <= {4'h0, n_mod} << div_sel_out;
      pfd_den_reg <= {1'b0, r_div} << halving;
    end
  end

  // ****************************************
  // Reference counter, halving and band clock
  // ****************************************
  wire ref_edge = ref_rise || (dbl && ref_fall);
  wire r_end    = ref_edge && (r_cnt_reg >= r_last);

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r_cnt_reg     <= 10'h000;
      r_pulse_reg   <= 1'b0;
      half_reg      <= 1'b0;
      cmp_pulse_reg <= 1'b0;
    end else begin
      r_pulse_reg   <= r_end;
      cmp_pulse_reg <= r_pulse_reg && (!halving || !half_reg);
      if (r_end) begin
        r_cnt_reg <= 10'h000;
      end else if (ref_edge) begin
        r_cnt_reg <= r_cnt_reg + 10'h001;
      end
      if (!halving) begin
        half_reg <= 1'b0;
      end else if (r_pulse_reg) begin
        half_reg <= !half_reg;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      band_cnt_reg  <= 8'h00;
      band_tick_reg <= 1'b0;
    end else begin
      band_tick_reg <= r_pulse_reg && (band_cnt_reg >= b_last);
      if (r_pulse_reg) begin
        band_cnt_reg <= (band_cnt_reg >= b_last) ? 8'h00 : band_cnt_reg + 8'h01;
      end
    end
  end

  // ****************************************
  // Digital lock detect
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lock_cnt_reg <= 6'h00;
      lock_reg     <= 1'b0;
    end else if (!vco_on) begin
      lock_cnt_reg <= 6'h00;
      lock_reg     <= 1'b0;
    end else if (cmp_pulse_reg) begin
      if (!phase_ok) begin
        lock_cnt_reg <= 6'h00;
        lock_reg     <= 1'b0;
      end else if (lock_cnt_reg < LOCK_CYCLES) begin
        lock_cnt_reg <= lock_cnt_reg + 6'h01;
        lock_reg     <= (lock_cnt_reg == LOCK_CYCLES - 6'h01);
      end
    end
  end

  // ****************************************
  // Cycle slip reduction cells
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cells_reg   <= 3'h0;
      falling_reg <= 1'b0;
    end else if (!csr_en) begin
      cells_reg   <= 3'h0;
      falling_reg <= 1'b0;
    end else if (cmp_pulse_reg) begin
      if (past || falling_reg) begin
        falling_reg <= (cells_reg > 3'h1);
        if (cells_reg != 3'h0) begin
          cells_reg <= cells_reg - 3'h1;
        end
      end else if (slip && (cells_reg < CP_CELLS_MAX)) begin
        cells_reg <= cells_reg + 3'h1;
      end
    end
  end

endmodule : synth_cfg_device

// ---- synth_output_lock_config_asserts.sv ----
// Checker: framing of the serial link between the host and device ends.
// Assumes the link wires change only just after clk_sys_in rising edges.
`timescale 1ns/1ps
module synth_output_lock_config_asserts (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_le
);
  // ****************************************
  // Serial clock count within one word
  // ****************************************
  logic       clk_q_reg;
  logic [6:0] bit_cnt_reg;
  logic [6:0] bit_cnt_next;

  assign bit_cnt_next = ser_le ? 7'h00 : bit_cnt_reg + {6'h00, ser_clk & ~clk_q_reg};

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_q_reg   <= 1'b0;
      bit_cnt_reg <= 7'h00;
    end else begin
      clk_q_reg   <= ser_clk;
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  // ****************************************
  // Link framing
  // ****************************************
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence le_pulse;
    ser_le [*4] ##1 !ser_le [*4];
  endsequence

  sequence clk_pulse;
    ser_clk [*4] ##1 !ser_clk;
  endsequence

  le_width_a: assert property ($rose(ser_le) |-> le_pulse)
    else $error("latch pulse width wrong");
  frame_bits_a: assert property ($rose(ser_le) |-> bit_cnt_reg == 7'h20)
    else $error("word not 32 bits");
  frame_max_a: assert property (bit_cnt_reg <= 7'h20)
    else $error("too many serial clocks");
  clk_high_a: assert property ($rose(ser_clk) |-> clk_pulse)
    else $error("serial clock high phase wrong");
  clk_low_a: assert property ($fell(ser_clk) |-> !ser_clk [*4])
    else $error("serial clock low phase short");
  data_hold_a: assert property (ser_clk |-> $stable(ser_data))
    else $error("data moved while clock high");
  le_clk_excl_a: assert property (ser_le |-> !ser_clk)
    else $error("clock and latch both high");
  frame_gap_a: assert property ($fell(ser_le) |-> !ser_clk [*8])
    else $error("next word started too soon");
endmodule : synth_output_lock_config_asserts

// ---- synth_output_lock_config_tb.sv ----
// Testbench: host and device ends joined by the serial interface.
// Assumes the package, interface, both ends and the checker are compiled first.
`timescale 1ns/1ps
module synth_output_lock_config_tb;
  import synth_cfg_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        clk_sys_in, rst_n_in, word_valid_in, word_ready_out, init_done_out, order_err_out;
  logic        ref_in, phase_ok_in, slip_imminent_in, past_target_in, vco_en_out, rf_en_out;
  logic        aux_en_out, aux_sel_out, band_tick_out, cmp_pulse_out, digital_lock_out, ld_pin_out;
  logic        csr_en_out, limit_warn_out, ref_duty_ok;
  logic [31:0] word_in;
  logic [1:0]  rf_pwr_out, aux_pwr_out, pfd_ratio_num_out, ref_div;
  logic [2:0]  div_sel_out, cp_cells_out;
  logic [11:0] fractional_modulus_out;
  logic [27:0] vco_ratio_num_out;
  logic [15:0] out_ratio_den_out;
  logic [10:0] pfd_ratio_den_out;
  int          fail_count, n_checks, n_refused, n_cmp, n_warn, cyc, c0;

  synth_serial_if link_if ();
  synth_cfg_host i_synth_cfg_host (.clk_sys_in, .rst_n_in, .link(link_if), .word_in, .word_valid_in,
    .word_ready_out, .ref_khz_in(16'h4E20), .ref_duty_ok_in(ref_duty_ok), .init_done_out, .order_err_out,
    .limit_warn_out);
  synth_cfg_device i_synth_cfg_device (.clk_sys_in, .rst_n_in, .link(link_if), .ref_in, .phase_ok_in,
    .slip_imminent_in, .past_target_in, .vco_en_out, .rf_en_out, .rf_pwr_out, .aux_en_out, .aux_sel_out,
    .aux_pwr_out, .div_sel_out, .band_tick_out, .cmp_pulse_out, .digital_lock_out, .ld_pin_out,
    .csr_en_out, .cp_cells_out, .fractional_modulus_out, .vco_ratio_num_out, .out_ratio_den_out,
    .pfd_ratio_num_out, .pfd_ratio_den_out);
  synth_output_lock_config_asserts i_synth_output_lock_config_asserts (.clk_sys_in, .rst_n_in,
    .ser_clk(link_if.ser_clk), .ser_data(link_if.ser_data), .ser_le(link_if.ser_le));

  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  // Reference of eight clocks a period, plus event counters
  always @(posedge clk_sys_in) begin
    ref_div <= ref_div + 2'h1;
    cyc <= cyc + 1;
    if (ref_div == 2'h3) ref_in <= ~ref_in;
    if (order_err_out === 1'b1) n_refused <= n_refused + 1;
    if (cmp_pulse_out === 1'b1) n_cmp <= n_cmp + 1;
    if (limit_warn_out === 1'b1) n_warn <= n_warn + 1;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic timeout();
    fail_count++;
    $display("wrong value at %0t: wait ran out", $time);
    stop_test();
  endtask : timeout

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check

  task automatic send(input logic [31:0] w);
    int i;
    i = 0;
    @(posedge clk_sys_in);
    word_in       <= w;
    word_valid_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      i++;
    end while (word_ready_out !== 1'b1 && i < 1000);
    word_valid_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    while (word_ready_out !== 1'b1 && i < 1000) begin
      @(posedge clk_sys_in);
      i++;
    end
    if (i >= 1000) timeout();
    repeat (10) @(posedge clk_sys_in);
  endtask : send

  task automatic wait_pulse(input bit band);
    int i;
    i = 0;
    do begin
      @(posedge clk_sys_in);
      i++;
    end while ((band ? band_tick_out : cmp_pulse_out) !== 1'b1 && i < 200);
    if (i >= 200) timeout();
  endtask : wait_pulse

  task automatic out4(input logic [31:0] w);
    check(vco_en_out, !w[11], "vco en");
    check(rf_en_out, w[5] & !w[11], "rf en");
    check(rf_pwr_out, w[4:3], "rf pwr");
    check(aux_en_out, w[8] & !w[11], "aux en");
    check(aux_sel_out, w[9], "aux sel");
    check(aux_pwr_out, w[7:6], "aux pwr");
    check(div_sel_out, w[22:20], "div sel");
  endtask : out4

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_init();
    check(vco_en_out, 1'b1, "reset vco");
    check(cp_cells_out, 3'h0, "reset cells");
    send(32'h0000_0004);
    check(n_refused, 1, "early word 4");
    send(32'h00C0_0005);
    check(ld_pin_out, 1'b1, "ld high");
    send(32'h0004_0003);
    check(n_refused, 2, "early word 3");
    send(32'h0010_13AC);
    check(n_warn, 1, "band limit");
    out4(32'h0010_13AC);
    send(32'h0004_0003);
    check(csr_en_out, 1'b1, "slip reduction");
    send(32'h0300_C002);
    check(pfd_ratio_num_out, 2'h2, "pfd num");
    check(pfd_ratio_den_out, 11'h006, "pfd den");
    send(32'h0000_7FF9);
    check(fractional_modulus_out, 12'hFFF, "modulus");
    check(init_done_out, 1'b0, "init early");
    send(32'h00D3_0068);
    check(vco_ratio_num_out, 422 * 4095 + 13, "vco ratio");
    check(out_ratio_den_out, 4095 * 2, "out ratio");
    check(init_done_out, 1'b1, "init done");
    $display("test init done");
  endtask : t_init

  task automatic t_fields();
    send(32'h0040_0974);
    out4(32'h0040_0974);
    send(32'hFFFF_FFFE);
    send(32'hFFFF_FFFF);
    out4(32'h0040_0974);
    check(ld_pin_out, 1'b1, "ld kept");
    for (int m = 0; m < 4; m++) begin
      send({8'h00, m[1:0], 19'h0_0000, 3'h5});
      check(ld_pin_out, m == 3, "ld mode");
    end
    out4(32'h0040_0974);
    $display("test fields done");
  endtask : t_fields

  task automatic t_lock();
    send(32'h0000_4002);
    send(32'h0000_3424);
    send(32'h0040_0005);
    check(rf_en_out, 1'b0, "muted");
    wait_pulse(1'b0);
    phase_ok_in <= 1'b1;
    for (int k = 1; k <= 40; k++) begin
      wait_pulse(1'b0);
      repeat (2) @(posedge clk_sys_in);
      check(digital_lock_out, k == 40, "lock");
    end
    check(rf_en_out, 1'b1, "unmuted");
    check(ld_pin_out, 1'b1, "ld lock");
    wait_pulse(1'b1);
    c0 = n_cmp;
    wait_pulse(1'b1);
    check(n_cmp - c0, 3, "band divide");
    phase_ok_in <= 1'b0;
    repeat (2) wait_pulse(1'b0);
    repeat (2) @(posedge clk_sys_in);
    check(digital_lock_out, 1'b0, "lock lost");
    check(rf_en_out, 1'b0, "muted again");
    $display("test lock done");
  endtask : t_lock

  task automatic t_csr();
    wait_pulse(1'b0);
    slip_imminent_in <= 1'b1;
    for (int k = 1; k <= 9; k++) begin
      wait_pulse(1'b0);
      repeat (2) @(posedge clk_sys_in);
      check(cp_cells_out, (k > 7) ? 7 : k, "cells up");
    end
    slip_imminent_in <= 1'b0;
    past_target_in   <= 1'b1;
    for (int k = 6; k >= -1; k--) begin
      wait_pulse(1'b0);
      repeat (2) @(posedge clk_sys_in);
      check(cp_cells_out, (k < 0) ? 0 : k, "cells down");
    end
    past_target_in <= 1'b0;
    $display("test slip done");
  endtask : t_csr

  task automatic t_half();
    logic [31:0] w [5] = '{32'h0000_4002, 32'h0100_4002, 32'h0300_4002, 32'h0200_4002, 32'h0000_4002};
    int          p [5] = '{8, 16, 8, 4, 16};
    for (int j = 0; j < 5; j++) begin
      ref_duty_ok <= (j != 4);
      send(w[j]);
      repeat (2) wait_pulse(1'b0);
      c0 = cyc;
      wait_pulse(1'b0);
      check(cyc - c0, p[j], "compare period");
    end
    ref_duty_ok <= 1'b1;
    check(n_warn, 4, "rate limit");
    $display("test halving done");
  endtask : t_half

  initial begin
    rst_n_in         = 1'b0;
    word_in          = WORD_RESET;
    word_valid_in    = 1'b0;
    ref_in           = 1'b0;
    ref_div          = 2'h0;
    ref_duty_ok      = 1'b1;
    phase_ok_in      = 1'b0;
    slip_imminent_in = 1'b0;
    past_target_in   = 1'b0;
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_init();
    t_fields();
    t_lock();
    t_csr();
    t_half();
    stop_test();
  end
endmodule : synth_output_lock_config_tb
